// ==== hw/exec_pkg.sv ====
/*
 * constants for the shift / branch / bit-change execution block.
 * assumes one core clock, active-high asynchronous reset, 32-bit reg port.
 */
// Functional notes
// - left shift sets V if bit 39 changes
// - left shift carry is last bit out
// - left shift zero-fills low, drops high bits
// - single right shift: LSB to carry, MSB kept
// - multi right shift sign-fills, 40-bit wide
// - count from 6-bit immediate or reg bits 5..0
// - shift count unsigned, range 0 to 40
// - count above 40 gives undefined result
// - right shift always clears overflow
// - right shift carry zero for count zero
// - branch taken adds displacement, else PC plus one
// - displacement is signed 16-bit distance
// - short displacement is sign-extended 9 bits
// - register form adds selected address pointer
// - branch leaves all condition flags alone
// - bit change inverts bit; copies it to carry except for status destination
// - bit number is immediate, 0 to 23
// - read and write done with bus locked
// - status destination inverts only chosen flag
// - other destinations: carry is tested bit
package exec_pkg;
    localparam int ACC_W = 40;
    localparam int PC_W = 16;
    localparam int WORD_W = 24;
    localparam int CNT_W = 6;
    localparam int BIT_W = 5;
    localparam int DISP_W = 9;
    localparam int NPTR = 8;
    localparam logic [6:0] MAX_SHIFT = 7'h28;
    localparam logic [7:0] OFS_CCR = 8'h00;
    localparam logic [7:0] OFS_PC = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_PTR0 = 8'h20;
    localparam logic [7:0] CCR_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam int CCR_C = 0;
    localparam int CCR_V = 1;
    localparam int CCR_Z = 2;
    localparam int CCR_N = 3;
    localparam int CCR_L = 6;
    localparam logic [2:0] OP_ASL1 = 3'h1;
    localparam logic [2:0] OP_ASLN = 3'h2;
    localparam logic [2:0] OP_ASR1 = 3'h3;
    localparam logic [2:0] OP_ASRN = 3'h4;
    localparam logic [2:0] OP_BRANCH = 3'h5;
    localparam logic [2:0] OP_BITINV = 3'h6;
endpackage : exec_pkg

// ==== hw/acc_shifter.sv ====
/*
 * combinational 40-bit arithmetic shifter, left or right.
 * assumes count already chosen and limited by the caller.
 */
`timescale 1ns/1ps
module acc_shifter
    import exec_pkg::*;
#(
    parameter int W = ACC_W
) (
    input wire logic [W-1:0] i_operand,
    input wire logic [CNT_W-1:0] i_count,
    input wire logic i_right,
    output logic [W-1:0] o_result,
    output logic o_carry,
    output logic o_overflow
);
    logic [2*W-1:0] left_ext;
    logic [2*W-1:0] right_ext;
    logic [W-1:0] ones;
    logic [W-1:0] seen_mask;
    logic [W-1:0] diff;
    logic fill_seen;
    // zero fill on the right, high bits drop off
    assign left_ext = {{W{1'b0}}, i_operand} << i_count;
    // sign fill, carry is the bit just below the result
    assign right_ext = $signed({i_operand, {W{1'b0}}}) >>> i_count;
    assign ones = {W{1'b1}};
    // bits that pass through the msb during the shift
    assign seen_mask = (~(ones >> i_count)) >> 1;
    assign diff = i_operand ^ {W{i_operand[W-1]}};
    assign o_result = i_right ? right_ext[2*W-1:W] : left_ext[W-1:0];
    // count zero leaves zero at both carry taps
    assign o_carry = i_right ? right_ext[W-1] : left_ext[W];
    // a full-width shift finally pushes a zero fill into the msb
    assign fill_seen = i_operand[W-1] && (int'(i_count) >= W);
    assign o_overflow = i_right ? 1'b0 : (|(diff & seen_mask) || fill_seen);
endmodule : acc_shifter

// ==== hw/bit_inverter.sv ====
/*
 * picks one bit of a word, reports it and returns the word with it inverted.
 * assumes bit number below the word width; larger numbers change nothing.
 */
`timescale 1ns/1ps
module bit_inverter
    import exec_pkg::*;
#(
    parameter int W = WORD_W
) (
    input wire logic [W-1:0] i_word,
    input wire logic [BIT_W-1:0] i_bit,
    output logic [W-1:0] o_word,
    output logic o_tested
);
    logic [W-1:0] sel;
    assign sel = {{(W-1){1'b0}}, 1'b1} << i_bit;
    assign o_tested = |(i_word & sel);
    assign o_word = i_word ^ sel;
endmodule : bit_inverter

// ==== hw/shift_branch_bit_change_exec.sv ====
/*
 * execution unit for arithmetic shifts, conditional branch and bit change.
 * assumes the issue side holds one operation per I_OP_VALID pulse and
 * waits while O_BUSY is high; memory answers a read in the next cycle.
 */
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module shift_branch_bit_change_exec
    import exec_pkg::*;
(
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [31:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [31:0] O_REG_RDATA,
    input wire logic I_OP_VALID,
    input wire logic [2:0] I_OP_CODE,
    input wire logic [ACC_W-1:0] I_SHIFT_OPERAND,
    input wire logic I_COUNT_FROM_REG,
    input wire logic [CNT_W-1:0] I_SHIFT_AMOUNT_IMM,
    input wire logic [15:0] I_SHIFT_COUNT_SOURCE_REG,
    input wire logic I_COND_TRUE,
    input wire logic I_BRANCH_REG_FORM,
    input wire logic [DISP_W-1:0] I_BRANCH_DISP,
    input wire logic [2:0] I_PTR_SEL,
    input wire logic I_BIT_TO_STATUS,
    input wire logic [BIT_W-1:0] I_BIT_NUM,
    input wire logic [15:0] I_MEM_ADDR,
    input wire logic [WORD_W-1:0] I_MEM_RDATA,
    output logic [ACC_W-1:0] O_ACC_RESULT,
    output logic O_ACC_WE,
    output logic [PC_W-1:0] O_PC,
    output logic [7:0] O_CCR,
    output logic O_BUSY,
    output logic O_MEM_RD,
    output logic O_MEM_WR,
    output logic O_MEM_LOCK,
    output logic [15:0] O_MEM_ADDR_OUT,
    output logic [WORD_W-1:0] O_MEM_WDATA
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_WAIT = 2'b10,
        ST_WRITE = 2'b11
    } state_t;

    ////////////////////////////////////////////////////////////////////
    // state
    state_t state_reg;
    state_t state_next;
    logic [7:0] ccr_reg;
    logic [PC_W-1:0] pc_reg;
    logic [PC_W-1:0] ptr_reg [NPTR];
    logic [ACC_W-1:0] acc_reg;
    logic acc_we_reg;
    logic [31:0] rdata_reg;
    logic mem_rd_reg;
    logic mem_wr_reg;
    logic mem_lock_reg;
    logic [15:0] mem_addr_reg;
    logic [WORD_W-1:0] mem_wdata_reg;
    logic [BIT_W-1:0] bit_num_reg;

    ////////////////////////////////////////////////////////////////////
    // operation decode
    wire is_asl1;
    wire is_asln;
    wire is_asr1;
    wire is_asrn;
    wire is_shift;
    wire is_right;
    wire is_branch;
    wire is_bitinv;
    wire go;
    assign go = I_OP_VALID && (state_reg == ST_IDLE);
    assign is_asl1 = go && (I_OP_CODE == OP_ASL1);
    assign is_asln = go && (I_OP_CODE == OP_ASLN);
    assign is_asr1 = go && (I_OP_CODE == OP_ASR1);
    assign is_asrn = go && (I_OP_CODE == OP_ASRN);
    assign is_shift = is_asl1 || is_asln || is_asr1 || is_asrn;
    assign is_right = is_asr1 || is_asrn;
    assign is_branch = go && (I_OP_CODE == OP_BRANCH);
    assign is_bitinv = go && (I_OP_CODE == OP_BITINV);

    ////////////////////////////////////////////////////////////////////
    // shift count and shifter
    wire [CNT_W-1:0] multi_count;
    wire [CNT_W-1:0] shift_count;
    wire [ACC_W-1:0] shift_result;
    wire shift_carry;
    wire shift_ovf;
    // only the low six bits of the source register count
    assign multi_count = I_COUNT_FROM_REG
        ? I_SHIFT_COUNT_SOURCE_REG[CNT_W-1:0]
        : I_SHIFT_AMOUNT_IMM;
    // unsigned count; above 40 the result is left undefined
    assign shift_count = (is_asl1 || is_asr1)
        ? {{(CNT_W-1){1'b0}}, 1'b1}
        : multi_count;

    acc_shifter #(
        .W(ACC_W)
    ) u_shifter (
        .i_operand(I_SHIFT_OPERAND),
        .i_count(shift_count),
        .i_right(is_right),
        .o_result(shift_result),
        .o_carry(shift_carry),
        .o_overflow(shift_ovf)
    );

    wire [7:0] shift_ccr;
    assign shift_ccr = {ccr_reg[7],
        ccr_reg[CCR_L] | shift_ovf,
        ccr_reg[5:4],
        shift_result[ACC_W-1],
        ~|shift_result,
        shift_ovf,
        shift_carry};

    ////////////////////////////////////////////////////////////////////
    // branch target
    wire [PC_W-1:0] short_disp;
    wire [PC_W-1:0] disp;
    wire [PC_W-1:0] pc_target;
    assign short_disp = {{(PC_W-DISP_W){I_BRANCH_DISP[DISP_W-1]}},
        I_BRANCH_DISP};
    assign disp = I_BRANCH_REG_FORM ? ptr_reg[I_PTR_SEL] : short_disp;
    // two's-complement add wraps in 16 bits
    assign pc_target = I_COND_TRUE
        ? pc_reg + disp
        : pc_reg + 16'h0001;

    ////////////////////////////////////////////////////////////////////
    // bit change on the status flags or on a fetched word
    wire [WORD_W-1:0] status_word_in;
    wire [WORD_W-1:0] status_word_out;
    wire status_tested;
    wire [WORD_W-1:0] mem_word_out;
    wire mem_tested;
    assign status_word_in = {{(WORD_W-8){1'b0}}, ccr_reg};

    bit_inverter #(
        .W(WORD_W)
    ) u_status_inv (
        .i_word(status_word_in),
        .i_bit(I_BIT_NUM),
        .o_word(status_word_out),
        .o_tested(status_tested)
    );

    bit_inverter #(
        .W(WORD_W)
    ) u_mem_inv (
        .i_word(I_MEM_RDATA),
        .i_bit(bit_num_reg),
        .o_word(mem_word_out),
        .o_tested(mem_tested)
    );

    // status destination: only the named flag flips, bits above 7 ignored
    wire [7:0] status_ccr;
    assign status_ccr = status_word_out[7:0];

    // other destinations: carry takes the tested bit, V/Z/N/U/E kept
    wire [7:0] mem_ccr;
    assign mem_ccr = {ccr_reg[7:1], mem_tested};

    ////////////////////////////////////////////////////////////////////
    // sequence for the locked read-modify-write
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (is_bitinv && !I_BIT_TO_STATUS) begin
                    state_next = ST_READ;
                end
            end
            ST_READ: begin
                state_next = ST_WAIT;
            end
            ST_WAIT: begin
                state_next = ST_WRITE;
            end
            ST_WRITE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // register port decode
    wire wr_ccr;
    wire wr_pc;
    wire wr_ptr;
    wire [2:0] ptr_idx;
    wire [31:0] rd_mux;
    assign wr_ccr = I_REG_WR && (I_REG_ADDR == OFS_CCR);
    assign wr_pc = I_REG_WR && (I_REG_ADDR == OFS_PC);
    assign wr_ptr = I_REG_WR && (I_REG_ADDR[7:5] == OFS_PTR0[7:5])
        && (I_REG_ADDR[1:0] == 2'b00);
    assign ptr_idx = I_REG_ADDR[4:2];
    assign rd_mux =
        (I_REG_ADDR == OFS_CCR) ? {24'h00_0000, ccr_reg} :
        (I_REG_ADDR == OFS_PC) ? {16'h0000, pc_reg} :
        (I_REG_ADDR == OFS_STATUS) ?
            {30'h0000_0000, mem_lock_reg, (state_reg != ST_IDLE)} :
        (I_REG_ADDR[7:5] == OFS_PTR0[7:5] && I_REG_ADDR[1:0] == 2'b00) ?
            {16'h0000, ptr_reg[ptr_idx]} :
        32'h0000_0000;

    ////////////////////////////////////////////////////////////////////
    // flags: an executing operation wins over a software write
    logic [7:0] ccr_next;
    always_comb begin
        ccr_next = ccr_reg;
        if (is_shift) begin
            ccr_next = shift_ccr;
        end else if (is_bitinv && I_BIT_TO_STATUS) begin
            ccr_next = status_ccr;
        end else if (state_reg == ST_WAIT) begin
            ccr_next = mem_ccr;
        end else if (wr_ccr && !is_branch) begin
            ccr_next = I_REG_WDATA[7:0];
        end else begin
            ccr_next = ccr_reg;
        end
    end

    logic [PC_W-1:0] pc_next;
    always_comb begin
        pc_next = pc_reg;
        if (is_branch) begin
            pc_next = pc_target;
        end else if (wr_pc) begin
            pc_next = I_REG_WDATA[PC_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // core flops
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            state_reg <= ST_IDLE;
            ccr_reg <= CCR_RESET;
            pc_reg <= PC_RESET;
            rdata_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            ccr_reg <= ccr_next;
            pc_reg <= pc_next;
            rdata_reg <= I_REG_RD ? rd_mux : 32'h0000_0000;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NPTR; gi++) begin : g_ptr
            always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
                if (I_RESET) begin
                    ptr_reg[gi] <= 16'h0000;
                end else if (wr_ptr && ptr_idx == 3'(gi)) begin
                    ptr_reg[gi] <= I_REG_WDATA[15:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            acc_reg <= '0;
            acc_we_reg <= 1'b0;
        end else begin
            acc_we_reg <= is_shift;
            if (is_shift) begin
                acc_reg <= shift_result;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // memory side of the bit change
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            mem_rd_reg <= 1'b0;
            mem_wr_reg <= 1'b0;
            mem_lock_reg <= 1'b0;
            mem_addr_reg <= 16'h0000;
            mem_wdata_reg <= '0;
            bit_num_reg <= '0;
        end else begin
            mem_rd_reg <= (state_next == ST_READ);
            mem_wr_reg <= (state_next == ST_WRITE);
            // lock spans the read through the write
            mem_lock_reg <= (state_next != ST_IDLE);
            if (is_bitinv) begin
                mem_addr_reg <= I_MEM_ADDR;
                bit_num_reg <= I_BIT_NUM;
            end
            if (state_reg == ST_WAIT) begin
                mem_wdata_reg <= mem_word_out;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    logic busy_reg;
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= (state_next != ST_IDLE);
        end
    end

    assign O_REG_RDATA = rdata_reg;
    assign O_ACC_RESULT = acc_reg;
    assign O_ACC_WE = acc_we_reg;
    assign O_PC = pc_reg;
    assign O_CCR = ccr_reg;
    assign O_BUSY = busy_reg;
    assign O_MEM_RD = mem_rd_reg;
    assign O_MEM_WR = mem_wr_reg;
    assign O_MEM_LOCK = mem_lock_reg;
    assign O_MEM_ADDR_OUT = mem_addr_reg;
    assign O_MEM_WDATA = mem_wdata_reg;

    wire unused_ok;
    assign unused_ok = status_tested;
endmodule : shift_branch_bit_change_exec

// ==== tb/exec_monitor.sv ====
/*
 * port-level concurrent checks for the shift / branch / bit-change unit.
 * assumes it is bound into the top module; one clock, active-high reset.
 */
`timescale 1ns/1ps
module exec_monitor
    import exec_pkg::*;
(
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    input wire logic I_REG_WR,
    input wire logic I_OP_VALID,
    input wire logic [2:0] I_OP_CODE,
    input wire logic I_COND_TRUE,
    input wire logic I_BRANCH_REG_FORM,
    input wire logic [DISP_W-1:0] I_BRANCH_DISP,
    input wire logic I_BIT_TO_STATUS,
    input wire logic [BIT_W-1:0] I_BIT_NUM,
    input wire logic [WORD_W-1:0] I_MEM_RDATA,
    input wire logic O_ACC_WE,
    input wire logic [PC_W-1:0] O_PC,
    input wire logic [7:0] O_CCR,
    input wire logic O_BUSY,
    input wire logic O_MEM_RD,
    input wire logic O_MEM_WR,
    input wire logic O_MEM_LOCK,
    input wire logic [WORD_W-1:0] O_MEM_WDATA
);
    default clocking mon_cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_RESET);

    ////////////////////////////////////////////////////////////////////////////////
    // issue decode
    wire logic take = I_OP_VALID && !O_BUSY;
    wire logic is_bitinv = I_OP_CODE == OP_BITINV;
    wire logic br_take = take && I_OP_CODE == OP_BRANCH && !I_REG_WR;
    wire logic br_fall = br_take && !I_COND_TRUE;
    wire logic br_short = br_take && I_COND_TRUE && !I_BRANCH_REG_FORM;
    wire logic st_take = take && is_bitinv && I_BIT_TO_STATUS && I_BIT_NUM < 5'h08 && !I_REG_WR;
    wire logic mem_take = take && is_bitinv && !I_BIT_TO_STATUS;
    wire logic asr_take = take && (I_OP_CODE == OP_ASR1 || I_OP_CODE == OP_ASRN);
    wire logic sh_take = take && I_OP_CODE >= OP_ASL1 && I_OP_CODE <= OP_ASRN;
    wire logic [15:0] disp_ext = {{7{I_BRANCH_DISP[8]}}, I_BRANCH_DISP};
    wire logic [7:0] st_mask = 8'h01 << I_BIT_NUM;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    mem_read_cause_a: assert property (O_MEM_RD |-> $past(mem_take))
        else $error("memory read without a bit change issue");
    lock_span_a: assert property (
        $rose(O_MEM_LOCK) |-> O_MEM_RD ##2 O_MEM_WR ##1 !O_MEM_LOCK)
        else $error("locked access sequence wrong");
    lock_hold_a: assert property (O_MEM_RD |-> O_MEM_LOCK [*3])
        else $error("bus lock dropped between read and write");
    wdata_flip_a: assert property (
        O_MEM_WR |-> $countones(O_MEM_WDATA ^ $past(I_MEM_RDATA)) == 1)
        else $error("written word differs from read word in other than one bit");
    carry_tested_a: assert property (
        O_MEM_WR |-> O_CCR[CCR_C] == |($past(I_MEM_RDATA) & ~O_MEM_WDATA))
        else $error("carry does not hold the tested bit");
    asr_no_ovf_a: assert property ($past(asr_take) |-> O_ACC_WE && !O_CCR[CCR_V])
        else $error("right shift left overflow set");
    acc_we_cause_a: assert property (O_ACC_WE |-> $past(sh_take))
        else $error("accumulator write without a shift");
    branch_flags_a: assert property ($past(br_take) |-> $stable(O_CCR))
        else $error("branch changed the flags");
    branch_fall_a: assert property (
        $past(br_fall) |-> O_PC == 16'($past(O_PC) + 16'h0001))
        else $error("untaken branch did not step by one");
    short_disp_a: assert property (
        $past(br_short) |-> O_PC == 16'($past(O_PC) + $past(disp_ext)))
        else $error("short branch target wrong");
    status_flip_a: assert property (
        $past(st_take) |-> O_CCR == ($past(O_CCR) ^ $past(st_mask)))
        else $error("status bit change touched the wrong flags");
endmodule : exec_monitor

// ==== tb/test_shift_branch_bit_change_exec.sv ====
/*
 * self-checking bench for the shift / branch / bit-change unit.
 * assumes exec_pkg and the port monitor are compiled before it.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("unexpected %s: expected %h seen %h", nm, ex, got); end end
module test_shift_branch_bit_change_exec
    import exec_pkg::*;
;
    logic I_CORE_CLK, I_RESET, I_REG_WR, I_REG_RD, I_OP_VALID, I_COUNT_FROM_REG, I_COND_TRUE;
    logic I_BRANCH_REG_FORM, I_BIT_TO_STATUS, O_ACC_WE, O_BUSY, O_MEM_RD, O_MEM_WR, O_MEM_LOCK;
    logic [7:0] I_REG_ADDR, O_CCR, flags_exp;
    logic [31:0] I_REG_WDATA, O_REG_RDATA;
    logic [2:0] I_OP_CODE, I_PTR_SEL;
    logic [ACC_W-1:0] I_SHIFT_OPERAND, O_ACC_RESULT;
    logic [CNT_W-1:0] I_SHIFT_AMOUNT_IMM;
    logic [15:0] I_SHIFT_COUNT_SOURCE_REG, I_MEM_ADDR, O_MEM_ADDR_OUT, O_PC, pc_exp;
    logic [DISP_W-1:0] I_BRANCH_DISP;
    logic [BIT_W-1:0] I_BIT_NUM;
    logic [WORD_W-1:0] I_MEM_RDATA, O_MEM_WDATA;
    logic [15:0] ptr [NPTR];
    int n_mismatch = 0, n_checks = 0, cycles = 0;

    shift_branch_bit_change_exec i_dut (.*);

    initial begin
        I_CORE_CLK = 1'b0;
        forever #2.5 I_CORE_CLK = ~I_CORE_CLK;
    end

    always @(posedge I_CORE_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // tasks
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge I_CORE_CLK);
        I_REG_ADDR <= a;
        I_REG_WDATA <= d;
        I_REG_WR <= 1'b1;
        @(posedge I_CORE_CLK);
        I_REG_WR <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        @(posedge I_CORE_CLK);
        I_REG_ADDR <= a;
        I_REG_RD <= 1'b1;
        @(posedge I_CORE_CLK);
        I_REG_RD <= 1'b0;
        #1;
        `CHK("register read", ex, O_REG_RDATA)
    endtask : rd

    // one-cycle issue; caller has set operands at the same edge
    task automatic go(input logic [2:0] code);
        I_OP_VALID <= 1'b1;
        I_OP_CODE <= code;
        @(posedge I_CORE_CLK);
        I_OP_VALID <= 1'b0;
        #1;
    endtask : go

    // returns {n, z, v, c, result}
    function automatic logic [43:0] shift_model(input logic [39:0] op, input int n, input bit left);
        logic [40:0] ext;
        logic [39:0] r;
        logic v;
        logic c;
        ext = {op, 1'b0};
        v = 1'b0;
        c = 1'b0;
        if (left) begin
            r = op << n;
            for (int k = 1; k <= n; k++)
                if (ext[40-k] != ext[40]) v = 1'b1;
            if (n > 0) c = op[40-n];
        end else begin
            r = 40'($signed(op) >>> n);
            if (n > 0) c = op[n-1];
        end
        return {r[39], r == 40'h00_0000_0000, v, c, r};
    endfunction : shift_model

    task automatic shift_op(input logic [2:0] code, input int n, input logic [39:0] op);
        logic [43:0] e;
        logic src;
        src = 1'($urandom);
        e = shift_model(op, (code == OP_ASL1 || code == OP_ASR1) ? 1 : n, code <= OP_ASLN);
        flags_exp = {flags_exp[7], flags_exp[6] | e[41], flags_exp[5:4], e[43:40]};
        @(posedge I_CORE_CLK);
        I_SHIFT_OPERAND <= op;
        I_COUNT_FROM_REG <= src;
        I_SHIFT_AMOUNT_IMM <= src ? 6'($urandom) : 6'(n);
        I_SHIFT_COUNT_SOURCE_REG <= {10'($urandom), src ? 6'(n) : 6'($urandom)};
        go(code);
        `CHK("result", {1'b1, e[39:0]}, {O_ACC_WE, O_ACC_RESULT})
        `CHK("carry", e[41:40], O_CCR[1:0])
        `CHK("flags", flags_exp, O_CCR)
    endtask : shift_op

    task automatic branch_op();
        logic cond;
        logic form;
        logic [8:0] d;
        logic [2:0] s;
        cond = 1'($urandom);
        form = 1'($urandom);
        d = 9'($urandom);
        s = 3'($urandom);
        pc_exp = !cond ? pc_exp + 16'h0001 : form ? pc_exp + ptr[s] : pc_exp + {{7{d[8]}}, d};
        @(posedge I_CORE_CLK);
        I_COND_TRUE <= cond;
        I_BRANCH_REG_FORM <= form;
        I_BRANCH_DISP <= d;
        I_PTR_SEL <= s;
        go(OP_BRANCH);
        `CHK("pc", pc_exp, O_PC)
        `CHK("flags after branch", flags_exp, O_CCR)
    endtask : branch_op

    task automatic bit_op(input logic to_status);
        logic [23:0] d;
        logic [4:0] b;
        logic [15:0] a;
        d = 24'($urandom);
        b = 5'($urandom_range(23, 0));
        a = 16'($urandom);
        @(posedge I_CORE_CLK);
        I_BIT_TO_STATUS <= to_status;
        I_BIT_NUM <= b;
        I_MEM_ADDR <= a;
        I_MEM_RDATA <= ~d;
        if (to_status) begin
            if (b < 5'h08) flags_exp[b] = ~flags_exp[b];
            go(OP_BITINV);
            `CHK("status flags", flags_exp, O_CCR)
        end else begin
            // issue held into the busy cycle, which must be ignored
            I_OP_VALID <= 1'b1;
            I_OP_CODE <= OP_BITINV;
            @(posedge I_CORE_CLK);
            #1;
            `CHK("rmw rd", {3'b111, a}, {O_MEM_RD, O_MEM_LOCK, O_BUSY, O_MEM_ADDR_OUT})
            @(posedge I_CORE_CLK);
            I_OP_VALID <= 1'b0;
            I_MEM_RDATA <= d;
            @(posedge I_CORE_CLK);
            I_MEM_RDATA <= ~d;
            #1;
            flags_exp[0] = d[b];
            `CHK("rmw wr", {2'b11, d ^ (24'h1 << b)}, {O_MEM_WR, O_MEM_LOCK, O_MEM_WDATA})
            `CHK("tested carry", flags_exp, O_CCR)
            @(posedge I_CORE_CLK);
            #1;
            `CHK("release", 4'h0, {O_MEM_RD, O_MEM_WR, O_MEM_LOCK, O_BUSY})
        end
    endtask : bit_op

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        int cnt [4] = '{0, 1, 39, 40};
        logic [39:0] ops [5] = '{40'h80_0000_0001, 40'h7f_ffff_ffff, 40'hc0_0000_0000,
            40'h00_0000_0001, 40'hff_ffff_ffff};
        logic [39:0] rop;
        int k;
        I_RESET = 1'b1;
        {I_REG_WR, I_REG_RD, I_OP_VALID, I_COUNT_FROM_REG, I_COND_TRUE, I_BRANCH_REG_FORM} = '0;
        {I_BIT_TO_STATUS, I_REG_ADDR, I_REG_WDATA, I_OP_CODE, I_PTR_SEL, I_SHIFT_OPERAND} = '0;
        {I_SHIFT_AMOUNT_IMM, I_SHIFT_COUNT_SOURCE_REG, I_MEM_ADDR, I_BRANCH_DISP, I_BIT_NUM} = '0;
        I_MEM_RDATA = '0;
        pc_exp = PC_RESET;
        flags_exp = CCR_RESET;
        void'($urandom(32'hd08b_a9fe));
        repeat (16) @(posedge I_CORE_CLK);
        I_RESET <= 1'b0;
        #1;
        `CHK("reset state", {pc_exp, flags_exp}, {O_PC, O_CCR})
        for (int i = 0; i < NPTR; i++) begin
            ptr[i] = 16'($urandom);
            wr(8'(OFS_PTR0 + 8'(4 * i)), {16'h0000, ptr[i]});
        end
        rd(8'(OFS_PTR0 + 8'h1c), {16'h0000, ptr[7]});
        rd(8'h10, 32'h0000_0000);
        rd(OFS_STATUS, 32'h0000_0000);
        flags_exp = 8'($urandom);
        wr(OFS_CCR, {24'h00_0000, flags_exp});
        rd(OFS_CCR, {24'h00_0000, flags_exp});
        pc_exp = 16'($urandom);
        wr(OFS_PC, {16'h0000, pc_exp});
        rd(OFS_PC, {16'h0000, pc_exp});
        $display("test registers done");
        for (int i = 0; i < 20; i++) begin
            shift_op(OP_ASLN, cnt[i % 4], ops[i / 4]);
            shift_op(OP_ASRN, cnt[i % 4], ops[i / 4]);
        end
        $display("test shift corners done");
        repeat (400) begin
            k = $urandom_range(7, 0);
            rop = 40'({$urandom, $urandom});
            if (k < 4) shift_op(3'(OP_ASL1 + k), $urandom_range(40, 0), rop);
            else if (k == 4) branch_op();
            else bit_op(k == 5);
        end
        $display("test random mix done");
        test_done();
    end
endmodule : test_shift_branch_bit_change_exec

bind shift_branch_bit_change_exec exec_monitor i_mon (.*);
